// ---- logic/agccfg_pkg.sv ----
// Package for the AGC and transmit power configuration register group.
// Assumes byte-wide registers at even byte offsets on a plain strobe port.
package agccfg_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int REG_COUNT = 12;
   localparam int REG_SHIFT = 1;
   localparam int IDX_W = 4;

   localparam logic [ADDR_W-1:0] OFS_LOCK_POS = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_BACKOFF = 8'h2a;
   localparam logic [ADDR_W-1:0] OFS_TABLE_ADDR = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_TABLE_DATA = 8'h2e;
   localparam logic [ADDR_W-1:0] OFS_LOOP_COEF = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_MANUAL_GAIN = 8'h32;
   localparam logic [ADDR_W-1:0] OFS_TEST_CTRL = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_RF_THRESH = 8'h36;
   localparam logic [ADDR_W-1:0] OFS_SAT_ATTEN = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_LOCK_NEG = 8'h3a;
   localparam logic [ADDR_W-1:0] OFS_CS_SCALE = 8'h3c;
   localparam logic [ADDR_W-1:0] OFS_TX_POWER = 8'h3e;

   localparam int R_LOCK_POS = int'(OFS_LOCK_POS - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_BACKOFF = int'(OFS_BACKOFF - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_TABLE_ADDR = int'(OFS_TABLE_ADDR - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_TABLE_DATA = int'(OFS_TABLE_DATA - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_LOOP_COEF = int'(OFS_LOOP_COEF - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_MANUAL_GAIN = int'(OFS_MANUAL_GAIN - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_TEST_CTRL = int'(OFS_TEST_CTRL - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_RF_THRESH = int'(OFS_RF_THRESH - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_SAT_ATTEN = int'(OFS_SAT_ATTEN - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_LOCK_NEG = int'(OFS_LOCK_NEG - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_CS_SCALE = int'(OFS_CS_SCALE - OFS_LOCK_POS) >> REG_SHIFT;
   localparam int R_TX_POWER = int'(OFS_TX_POWER - OFS_LOCK_POS) >> REG_SHIFT;

   // Field positions and widths
   localparam int WIN_LSB = 0;
   localparam int WIN_W = 5;
   localparam int MAXLOCK_LSB = 5;
   localparam int MAXLOCK_W = 3;
   localparam int BACKOFF_W = 6;
   localparam int TBL_ADDR_W = 5;
   localparam int TBL_RD_BIT = 5;
   localparam int GAIN_W = 7;
   localparam int MAN_RF_BIT = 7;
   localparam int CONT_BIT = 7;
   localparam int POL_BIT = 6;
   localparam int EXTRA_DIS_BIT = 5;
   localparam int OVR_BIT = 2;
   localparam int ABORT_BIT = 1;
   localparam int SAT_EN_BIT = 0;
   localparam int RF_DIS_BIT = 7;
   localparam int MID_LSB = 4;
   localparam int SAT_W = 4;
   localparam int BLK_LSB = 5;
   localparam int BLK_W = 3;
   localparam int CS_W = 6;
   localparam int TXP_LSB = 1;
   localparam int TXP_W = 7;
   localparam int LVL_W = 6;

   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } agccfg_bus_t;

   typedef struct packed {
      logic [GAIN_W-1:0] gain_value;
      logic [GAIN_W-1:0] if_gain;
      logic rf_pad_removed;
      logic [MAXLOCK_W-1:0] lock_updates;
      logic frozen;
      logic locked;
      logic second_search;
      logic second_weaker;
      logic [LVL_W-1:0] sat_level;
      logic mid_sat_over;
      logic low_sat_over;
   } agccfg_loop_t;

   typedef struct packed {
      logic [WIN_W-1:0] win_pos;
      logic signed [WIN_W:0] win_neg;
      logic [BACKOFF_W-1:0] backoff;
      logic [GAIN_W-1:0] loop_gain;
      logic [SAT_W:0] mid_atten;
      logic [SAT_W-1:0] low_atten;
      logic [CS_W-1:0] cs_scale;
   } agccfg_cfg_t;

   typedef struct packed {
      logic rf_gain;
      logic [GAIN_W-1:0] if_gain;
      logic search_allow;
      logic update_enable;
      logic extra_update;
      logic abort_second;
      logic sat_step_enable;
      logic [SAT_W:0] sat_atten;
   } agccfg_gain_t;

endpackage : agccfg_pkg

// ---- logic/agccfg_gain_table.sv ----
// Gain lookup table held in flip-flops, one write port, one read index.
// Assumes writes come from the register bank on the same clock.
`timescale 1ns/100ps
module agccfg_gain_table
   import agccfg_pkg::*;
#(
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_we,
   input wire logic [TBL_ADDR_W-1:0] i_addr,
   input wire logic [GAIN_W-1:0] i_wdata,
   output logic [GAIN_W-1:0] o_rdata
);
   // Refused at elaboration: the address field cannot reach more entries
   if (DEPTH < 1 || DEPTH > (1 << TBL_ADDR_W)) begin : g_bad_depth
      $error("agccfg_gain_table: DEPTH out of range");
   end

   typedef struct packed {
      logic [DEPTH-1:0][GAIN_W-1:0] entry;
   } agccfg_table_state_t;

   agccfg_table_state_t st;
   agccfg_table_state_t next_st;

   always_comb begin
      next_st = st;
      if (i_we && (32'(i_addr) < DEPTH)) begin
         next_st.entry[i_addr] = i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Entries beyond DEPTH read as zero
   assign o_rdata = (32'(i_addr) < DEPTH) ? st.entry[i_addr] : '0;

endmodule : agccfg_gain_table

// ---- logic/agccfg_tx_power.sv ----
// Transmit power hold: passes the programmed value to the power DAC.
// Assumes the transmit enable arrives from a pin, outside this clock.
`timescale 1ns/100ps
module agccfg_tx_power
   import agccfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_transmit_enable,
   input wire logic [TXP_W-1:0] i_power,
   output logic [TXP_W-1:0] o_power
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic [TXP_W-1:0] power;
   } agccfg_txp_state_t;

   agccfg_txp_state_t st;
   agccfg_txp_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.sync1 = i_transmit_enable;
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      // Mid-burst register writes must not move the DAC
      if (st.sync2 && !st.prev) begin
         next_st.power = i_power;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_power = st.power;

endmodule : agccfg_tx_power

// ---- logic/agccfg_regs.sv ----
// Register bank for receive AGC configuration and transmit power setting.
// Assumes a strobe bus master on I_CORE_CLK and an AGC loop on the same clock.
// What this block does
// - Allow antenna search when lock updates within maximum
// - Hold five-bit positive outer lock window
// - Negate programmed negative window magnitude internally
// - Six-bit backoff sets converter headroom
// - Table-read bit selects table or stored data
// - Five-bit table address, seven-bit entries
// - Seven-bit fractional loop gain to loop
// - Override drives RF and IF gain manually
// - Manual RF bit one removes pad
// - Polarity bit inverts RF gain output
// - Continuous bit keeps updates during freeze
// - One extra update after lock unless disabled
// - Abort weaker second antenna search when enabled
// - Test bit zero gates step inside window
// - Remove RF pad below RF threshold
// - RF disable bit ignores threshold comparison
// - Mid step doubles value; steps on counts
// - Hold four-bit low saturation attenuation
// - Suppress step at or below block level plus eight
// - Hold six-bit second carrier-sense scale
// - Transmit power latched on transmit enable rise
// - Unused bits stored, read back, ignored
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module agccfg_regs
   import agccfg_pkg::*;
#(
   parameter int TABLE_DEPTH = 32
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET,
   input wire agccfg_bus_t I_BUS,
   input wire agccfg_loop_t I_LOOP,
   input wire logic I_TRANSMIT_ENABLE,
   output logic [DATA_W-1:0] O_RDATA,
   output agccfg_cfg_t O_CFG,
   output agccfg_gain_t O_GAIN,
   output logic [TXP_W-1:0] O_TX_POWER
);
   // Refused at elaboration: the table address field is five bits
   if (TABLE_DEPTH < 1 || TABLE_DEPTH > (1 << TBL_ADDR_W)) begin : g_bad_depth
      $error("agccfg_regs: TABLE_DEPTH out of range");
   end

   typedef struct packed {
      logic [REG_COUNT-1:0][DATA_W-1:0] regs;
      logic [DATA_W-1:0] rdata;
      agccfg_cfg_t cfg;
      agccfg_gain_t gain;
      logic locked_prev;
   } agccfg_regs_state_t;

   agccfg_regs_state_t st;
   agccfg_regs_state_t next_st;

   // Bus decode
   logic [ADDR_W-1:0] offs;
   logic [IDX_W-1:0] idx;
   logic in_range;
   logic aligned;
   logic hit;

   // Table access
   logic [TBL_ADDR_W-1:0] tbl_addr;
   logic tbl_read_sel;
   logic tbl_we;
   logic [GAIN_W-1:0] tbl_rdata;

   // Fields of the stored registers
   logic [MAXLOCK_W-1:0] max_lock;
   logic [WIN_W-1:0] win_pos;
   logic [WIN_W-1:0] win_neg_mag;
   logic [BACKOFF_W-1:0] backoff;
   logic [GAIN_W-1:0] loop_gain;
   logic man_rf;
   logic [GAIN_W-1:0] man_if;
   logic cont_update;
   logic rf_invert;
   logic extra_dis;
   logic override;
   logic abort_en;
   logic sat_in_window_en;
   logic rf_thr_dis;
   logic [GAIN_W-1:0] rf_thr;
   logic [SAT_W-1:0] mid_sat;
   logic [SAT_W-1:0] low_sat;
   logic [BLK_W-1:0] blk_level;
   logic [CS_W-1:0] cs_scale;
   logic [TXP_W-1:0] tx_power;

   // Derived gain terms
   logic rf_auto;
   logic rf_sel;
   logic [LVL_W-1:0] blk_cmp;
   logic in_block_window;
   logic step_ok;
   logic [SAT_W:0] step_value;

   assign offs = I_BUS.addr - OFS_LOCK_POS;
   assign idx = offs[IDX_W+REG_SHIFT-1:REG_SHIFT];
   assign in_range = (I_BUS.addr >= OFS_LOCK_POS) && (I_BUS.addr <= OFS_TX_POWER);
   assign aligned = (I_BUS.addr[REG_SHIFT-1:0] == '0);
   assign hit = in_range && aligned;

   assign max_lock = st.regs[R_LOCK_POS][MAXLOCK_LSB +: MAXLOCK_W];
   assign win_pos = st.regs[R_LOCK_POS][WIN_LSB +: WIN_W];
   assign win_neg_mag = st.regs[R_LOCK_NEG][WIN_LSB +: WIN_W];
   assign blk_level = st.regs[R_LOCK_NEG][BLK_LSB +: BLK_W];
   assign backoff = st.regs[R_BACKOFF][BACKOFF_W-1:0];
   assign tbl_addr = st.regs[R_TABLE_ADDR][TBL_ADDR_W-1:0];
   assign tbl_read_sel = st.regs[R_TABLE_ADDR][TBL_RD_BIT];
   assign loop_gain = st.regs[R_LOOP_COEF][GAIN_W-1:0];
   assign man_rf = st.regs[R_MANUAL_GAIN][MAN_RF_BIT];
   assign man_if = st.regs[R_MANUAL_GAIN][GAIN_W-1:0];
   assign cont_update = st.regs[R_TEST_CTRL][CONT_BIT];
   assign rf_invert = st.regs[R_TEST_CTRL][POL_BIT];
   assign extra_dis = st.regs[R_TEST_CTRL][EXTRA_DIS_BIT];
   assign override = st.regs[R_TEST_CTRL][OVR_BIT];
   assign abort_en = st.regs[R_TEST_CTRL][ABORT_BIT];
   assign sat_in_window_en = st.regs[R_TEST_CTRL][SAT_EN_BIT];
   assign rf_thr_dis = st.regs[R_RF_THRESH][RF_DIS_BIT];
   assign rf_thr = st.regs[R_RF_THRESH][GAIN_W-1:0];
   assign mid_sat = st.regs[R_SAT_ATTEN][MID_LSB +: SAT_W];
   assign low_sat = st.regs[R_SAT_ATTEN][SAT_W-1:0];
   assign cs_scale = st.regs[R_CS_SCALE][CS_W-1:0];
   assign tx_power = st.regs[R_TX_POWER][TXP_LSB +: TXP_W];

   // Table entry written through the data register only while reads target it
   assign tbl_we = I_BUS.wr && hit && (idx == IDX_W'(R_TABLE_DATA)) && tbl_read_sel;

   agccfg_gain_table #(
      .DEPTH(TABLE_DEPTH)
   ) u_table (
      .i_clk(I_CORE_CLK),
      .i_reset(I_RESET),
      .i_we(tbl_we),
      .i_addr(tbl_addr),
      .i_wdata(I_BUS.wdata[GAIN_W-1:0]),
      .o_rdata(tbl_rdata)
   );

   agccfg_tx_power u_tx_power (
      .i_clk(I_CORE_CLK),
      .i_reset(I_RESET),
      .i_transmit_enable(I_TRANSMIT_ENABLE),
      .i_power(tx_power),
      .o_power(O_TX_POWER)
   );

   // RF pad: manual bit under override, else threshold, else loop
   always_comb begin
      rf_auto = I_LOOP.rf_pad_removed;
      if (!rf_thr_dis) begin
         rf_auto = (I_LOOP.gain_value < rf_thr);
      end
      rf_sel = override ? man_rf : rf_auto;
   end

   // Saturation step gating and size
   always_comb begin
      blk_cmp = LVL_W'({1'b1, blk_level});
      in_block_window = (I_LOOP.sat_level <= blk_cmp);
      step_ok = !in_block_window || sat_in_window_en;
      step_value = '0;
      if (I_LOOP.mid_sat_over) begin
         step_value = {mid_sat, 1'b0};
      end else if (I_LOOP.low_sat_over) begin
         step_value = {1'b0, low_sat};
      end
      if (!step_ok) begin
         step_value = '0;
      end
   end

   always_comb begin
      next_st = st;
      next_st.locked_prev = I_LOOP.locked;

      // All eight bits kept, spare ones included
      if (I_BUS.wr && hit) begin
         next_st.regs[idx] = I_BUS.wdata;
      end

      // Read data valid only in the cycle after the strobe
      next_st.rdata = '0;
      if (I_BUS.rd && hit) begin
         if ((idx == IDX_W'(R_TABLE_DATA)) && tbl_read_sel) begin
            next_st.rdata = DATA_W'(tbl_rdata);
         end else begin
            next_st.rdata = st.regs[idx];
         end
      end

      next_st.cfg.win_pos = win_pos;
      next_st.cfg.win_neg = -$signed({1'b0, win_neg_mag});
      next_st.cfg.backoff = backoff;
      next_st.cfg.loop_gain = loop_gain;
      next_st.cfg.mid_atten = {mid_sat, 1'b0};
      next_st.cfg.low_atten = low_sat;
      next_st.cfg.cs_scale = cs_scale;

      next_st.gain.rf_gain = rf_sel ^ rf_invert;
      next_st.gain.if_gain = override ? man_if : I_LOOP.if_gain;
      next_st.gain.search_allow = (I_LOOP.lock_updates <= max_lock);
      // Locked counts as frozen for the update gate
      next_st.gain.update_enable = cont_update || !(I_LOOP.frozen || I_LOOP.locked);
      next_st.gain.extra_update = I_LOOP.locked && !st.locked_prev && !extra_dis;
      next_st.gain.abort_second = abort_en && I_LOOP.second_search && I_LOOP.second_weaker;
      next_st.gain.sat_step_enable = step_ok;
      next_st.gain.sat_atten = step_value;
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         st <= '0;
         for (int i = 0; i < REG_COUNT; i++) begin
            st.regs[i] <= REG_RESET;
         end
      end else begin
         st <= next_st;
      end
   end

   assign O_RDATA = st.rdata;
   assign O_CFG = st.cfg;
   assign O_GAIN = st.gain;

endmodule : agccfg_regs

// ---- testbench/agccfg_regs_chk.sv ----
// Checker for the AGC configuration bank, port level only.
// Assumes the bind below; a shadow of bus writes mirrors the bank.
`timescale 1ns/100ps
module agccfg_regs_chk
   import agccfg_pkg::*;
(
   input wire logic I_CORE_CLK,
   input wire logic I_RESET,
   input wire agccfg_bus_t I_BUS,
   input wire agccfg_loop_t I_LOOP,
   input wire logic I_TRANSMIT_ENABLE,
   input wire logic [DATA_W-1:0] O_RDATA,
   input wire agccfg_cfg_t O_CFG,
   input wire agccfg_gain_t O_GAIN,
   input wire logic [TXP_W-1:0] O_TX_POWER
);
   logic [DATA_W-1:0] sh [REG_COUNT];
   logic [DATA_W-1:0] tst;
   logic [DATA_W-1:0] thr;
   logic e_rf;
   logic e_upd;
   logic e_abort;
   logic e_allow;
   logic [GAIN_W-1:0] e_if;
   logic signed [WIN_W:0] e_neg;
   logic [SAT_W:0] e_mid;
   logic [TXP_W-1:0] e_tx;
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RESET);
   // Odd and unmapped writes dropped, as in the bank
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         for (int i = 0; i < REG_COUNT; i++) sh[i] <= REG_RESET;
      end else if (I_BUS.wr && !I_BUS.addr[0] && I_BUS.addr >= OFS_LOCK_POS && I_BUS.addr <= OFS_TX_POWER) begin
         sh[IDX_W'((I_BUS.addr - OFS_LOCK_POS) >> REG_SHIFT)] <= I_BUS.wdata;
      end
   end
   always_comb begin
      tst = sh[R_TEST_CTRL];
      thr = sh[R_RF_THRESH];
      e_rf = (tst[OVR_BIT] ? sh[R_MANUAL_GAIN][MAN_RF_BIT] : (thr[RF_DIS_BIT] ? I_LOOP.rf_pad_removed
         : I_LOOP.gain_value < thr[GAIN_W-1:0])) ^ tst[POL_BIT];
      e_if = tst[OVR_BIT] ? sh[R_MANUAL_GAIN][GAIN_W-1:0] : I_LOOP.if_gain;
      e_upd = tst[CONT_BIT] | !(I_LOOP.frozen | I_LOOP.locked);
      e_abort = tst[ABORT_BIT] & I_LOOP.second_search & I_LOOP.second_weaker;
      e_allow = I_LOOP.lock_updates <= sh[R_LOCK_POS][7:5];
      e_neg = -$signed({1'b0, sh[R_LOCK_NEG][WIN_W-1:0]});
      e_mid = {sh[R_SAT_ATTEN][7:4], 1'b0};
      e_tx = sh[R_TX_POWER][7:1];
   end
   a_rf_gain_line: assert property (!$past(I_RESET) |-> O_GAIN.rf_gain == $past(e_rf))
      else $error("rf gain line wrong");
   a_if_gain_line: assert property (!$past(I_RESET) |-> O_GAIN.if_gain == $past(e_if))
      else $error("if gain line wrong");
   a_update_enable: assert property (!$past(I_RESET) |-> O_GAIN.update_enable == $past(e_upd))
      else $error("update enable wrong");
   a_abort_second: assert property (!$past(I_RESET) |-> O_GAIN.abort_second == $past(e_abort))
      else $error("second antenna abort wrong");
   a_search_allow: assert property (!$past(I_RESET) |-> O_GAIN.search_allow == $past(e_allow))
      else $error("search allow wrong");
   a_neg_window: assert property (!$past(I_RESET) |-> O_CFG.win_neg == $past(e_neg))
      else $error("negative window not negated");
   a_mid_double: assert property (!$past(I_RESET) |-> O_CFG.mid_atten == $past(e_mid))
      else $error("mid step not doubled");
   a_extra_after_lock: assert property ($rose(I_LOOP.locked) && !tst[EXTRA_DIS_BIT] |=> O_GAIN.extra_update)
      else $error("extra update missing");
   a_extra_one_shot: assert property (O_GAIN.extra_update |=> !O_GAIN.extra_update)
      else $error("extra update longer than one cycle");
   a_tx_on_enable: assert property ($changed(O_TX_POWER) |-> $past(I_TRANSMIT_ENABLE) && O_TX_POWER == $past(e_tx))
      else $error("transmit power moved without enable");
endmodule : agccfg_regs_chk

bind agccfg_regs agccfg_regs_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_BUS(I_BUS),
   .I_LOOP(I_LOOP), .I_TRANSMIT_ENABLE(I_TRANSMIT_ENABLE), .O_RDATA(O_RDATA), .O_CFG(O_CFG),
   .O_GAIN(O_GAIN), .O_TX_POWER(O_TX_POWER));

// ---- testbench/agccfg_host_model.sv ----
// Controlling processor model on the register strobe port.
// Assumes one clock; read data taken the cycle after the strobe.
`timescale 1ns/100ps
module agccfg_host_model
   import agccfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic [DATA_W-1:0] i_rdata,
   output agccfg_bus_t o_bus
);
   initial o_bus = '0;
   // Idle bus shows the inverted address, and the inverted data after a write, so stale data never looks valid
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge i_clk);
      o_bus <= '{addr: a, wdata: ~o_bus.wdata, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      o_bus <= '{addr: ~a, wdata: o_bus.wdata, wr: 1'b0, rd: 1'b0};
      #1;
      d = i_rdata;
   endtask : rd
endmodule : agccfg_host_model

// ---- testbench/agccfg_regs_tb_top.sv ----
// Testbench for the AGC configuration register bank.
// Assumes the host model for bus cycles and the bound checker.
`timescale 1ns/100ps
module agccfg_regs_tb_top
   import agccfg_pkg::*;
;
   logic I_CORE_CLK = 1'b0;
   logic I_RESET = 1'b1;
   logic I_TRANSMIT_ENABLE = 1'b0;
   agccfg_bus_t bus;
   agccfg_loop_t loop = '0;
   logic [DATA_W-1:0] rdata;
   agccfg_cfg_t cfg;
   agccfg_gain_t gain;
   logic [TXP_W-1:0] txp;
   int fails = 0;
   int compares = 0;
   always #12.5 I_CORE_CLK = ~I_CORE_CLK;
   agccfg_regs #(.TABLE_DEPTH(32)) DUT (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_BUS(bus), .I_LOOP(loop),
      .I_TRANSMIT_ENABLE(I_TRANSMIT_ENABLE), .O_RDATA(rdata), .O_CFG(cfg), .O_GAIN(gain), .O_TX_POWER(txp));
   agccfg_host_model host (.i_clk(I_CORE_CLK), .i_rdata(rdata), .o_bus(bus));
   task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] v;
      host.rd(a, v);
      check($sformatf("reg %h", a), v, exp);
   endtask : rchk
   task automatic settle;
      repeat (3) @(posedge I_CORE_CLK);
   endtask : settle
   task automatic tally_and_finish;
      if (fails == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (4) @(posedge I_CORE_CLK);
      I_RESET <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) rchk(OFS_LOCK_POS + ADDR_W'(2 * i), 8'h00);
      for (int i = 0; i < REG_COUNT; i++) host.wr(OFS_LOCK_POS + ADDR_W'(2 * i), 8'h9f - DATA_W'(i));
      host.wr(8'h40, 8'h5a);
      host.wr(8'h29, 8'h5a);
      for (int i = 0; i < REG_COUNT; i++) rchk(OFS_LOCK_POS + ADDR_W'(2 * i), 8'h9f - DATA_W'(i));
      rchk(8'h40, 8'h00);
      rchk(8'h29, 8'h00);
      check("win_pos", cfg.win_pos, 8'h1f);
      check("backoff", cfg.backoff, 8'h1e);
      check("loop_gain", cfg.loop_gain, 8'h1b);
      check("cs_scale", cfg.cs_scale, 8'h15);
      check("low_atten", cfg.low_atten, 8'h07);
      // Table entries land through the data register while bit 5 is set
      host.wr(OFS_TABLE_ADDR, 8'h3f);
      host.wr(OFS_TABLE_DATA, 8'hc5);
      host.wr(OFS_TABLE_ADDR, 8'h20);
      host.wr(OFS_TABLE_DATA, 8'h7f);
      host.wr(OFS_TABLE_ADDR, 8'h3f);
      rchk(OFS_TABLE_DATA, 8'h45);
      host.wr(OFS_TABLE_ADDR, 8'h1f);
      rchk(OFS_TABLE_DATA, 8'h7f);
      for (int i = 0; i < 4; i++) begin
         host.wr(OFS_MANUAL_GAIN, {i[0], 7'h2b});
         host.wr(OFS_TEST_CTRL, {1'b0, i[1], 6'h04});
         settle;
         check("rf_manual", gain.rf_gain, i[0] ^ i[1]);
         check("if_manual", gain.if_gain, 8'h2b);
      end
      host.wr(OFS_TEST_CTRL, 8'h00);
      host.wr(OFS_RF_THRESH, 8'h40);
      for (int i = 0; i < 3; i++) begin
         @(posedge I_CORE_CLK);
         loop.gain_value <= (i == 2) ? 7'h00 : 7'h3f + GAIN_W'(i);
         if (i == 2) host.wr(OFS_RF_THRESH, 8'hc0);
         settle;
         check("rf_thresh", gain.rf_gain, 8'(i == 0));
      end
      @(posedge I_CORE_CLK);
      loop <= '{lock_updates: 3'd5, frozen: 1'b1, second_search: 1'b1, second_weaker: 1'b1, default: '0};
      for (int i = 0; i < 2; i++) begin
         host.wr(OFS_LOCK_POS, {2'b10, i[0], 5'h00});
         host.wr(OFS_TEST_CTRL, {i[0], 5'h00, i[0], 1'b0});
         settle;
         check("search_allow", gain.search_allow, 8'(i));
         check("update_enable", gain.update_enable, 8'(i));
         check("abort_second", gain.abort_second, 8'(i));
      end
      for (int i = 0; i < 2; i++) begin
         host.wr(OFS_TEST_CTRL, {2'b10, i[0], 5'h02});
         @(posedge I_CORE_CLK);
         loop.locked <= 1'b1;
         @(posedge I_CORE_CLK);
         #1;
         check("extra_update", gain.extra_update, 8'(i == 0));
         @(posedge I_CORE_CLK);
         loop.locked <= 1'b0;
      end
      host.wr(OFS_SAT_ATTEN, 8'hf7);
      host.wr(OFS_LOCK_NEG, 8'h1f);
      for (int i = 0; i < 4; i++) begin
         @(posedge I_CORE_CLK);
         loop.mid_sat_over <= (i != 3);
         loop.low_sat_over <= 1'b1;
         loop.sat_level <= (i == 1) ? 6'h09 : 6'h08;
         host.wr(OFS_TEST_CTRL, {7'h00, i[1]});
         settle;
         check("sat_atten", gain.sat_atten, (i == 0) ? 8'h00 : (i == 3) ? 8'h07 : 8'h1e);
         check("sat_step", gain.sat_step_enable, 8'(i != 0));
      end
      check("win_neg", {2'b00, cfg.win_neg}, 8'h21);
      check("mid_atten", cfg.mid_atten, 8'h1e);
      host.wr(OFS_TX_POWER, 8'h81);
      settle;
      check("tx_idle", txp, 8'h00);
      for (int i = 0; i < 2; i++) begin
         @(posedge I_CORE_CLK);
         I_TRANSMIT_ENABLE <= 1'b1;
         settle;
         host.wr(OFS_TX_POWER, 8'h7e);
         settle;
         check("tx_power", txp, i ? 8'h3f : 8'h40);
         @(posedge I_CORE_CLK);
         I_TRANSMIT_ENABLE <= 1'b0;
         settle;
      end
      // Reset in mid-run must clear everything again
      @(posedge I_CORE_CLK);
      I_RESET <= 1'b1;
      repeat (2) @(posedge I_CORE_CLK);
      I_RESET <= 1'b0;
      rchk(OFS_TEST_CTRL, 8'h00);
      check("tx_reset", txp, 8'h00);
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge I_CORE_CLK);
      fails++;
      tally_and_finish;
   end
endmodule : agccfg_regs_tb_top
